// *** hdl/pdc_ctrl.sv ***
// Power-down mode controller with AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`include "pdc_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module pdc_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sleep_exec,
    input wire logic hw_standby_pin,
    input wire logic wdt_watchdog_mode,
    input wire logic irq_any,
    input wire logic irq_external,
    input wire logic irq_timer_wdt,
    input wire logic periph_clk_tick,
    output logic sleep_exception,
    output logic cpu_halt,
    output logic osc_stop,
    output logic wdt_halt,
    output logic [31:0] module_halt,
    output logic [31:0] module_reset,
    output logic [3:0] timer_halt,
    output logic timer_pin_off,
    output logic wake_resume,
    output logic bus_float_n,
    output logic port_hold,
    output logic port_hiz_n,
    output logic [15:0] clock_divider_control
);
    pdc_pkg::pdc_state_e state;
    pdc_pkg::pdc_state_e next_state;
    pdc_pkg::pdc_ahb_req_s req;
    logic [15:0] standby_control;
    logic [31:0] module_halt_reg_a;
    logic [31:0] module_halt_reg_b;
    logic [31:0] module_halt_reg_c;
    logic [19:0] settle_cnt;
    logic [19:0] settle_len;
    logic wr_go;
    logic rd_go;
    logic [4:0] sts;
    logic soft_standby_select;
    logic bus_output_hold_enable;
    logic sleep_exception_enable;

    assign soft_standby_select = standby_control[`PDC_BIT_SOFT_STANDBY_SELECT];
    assign bus_output_hold_enable = standby_control[`PDC_BIT_HOLD];
    assign sleep_exception_enable = standby_control[`PDC_BIT_SLEEP_EXCEPTION_ENABLE];
    assign sts = standby_control[`PDC_STS_HI:`PDC_STS_LO];

    // Always zero wait, OKAY only
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= '0;
        end else if (hready) begin
            req.sel <= hsel & htrans[1];
            req.addr <= haddr;
            req.write <= hwrite;
            req.size <= hsize;
            req.trans <= htrans;
        end
    end
    assign wr_go = req.sel & req.write;
    assign rd_go = hsel & htrans[1] & ~hwrite & hready;

    // Standby control register; wake never touches the select bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            standby_control <= `PDC_SBY_RST;
        end else if (wr_go && req.addr[11:0] == `PDC_OFF_SBY) begin
            standby_control <= hwdata[15:0] & `PDC_SBY_WMASK;
        end
    end

    // Module halt registers, every bit halted after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            module_halt_reg_a <= `PDC_HALTA_RST;
            module_halt_reg_b <= `PDC_HALTB_RST;
            module_halt_reg_c <= `PDC_HALTC_RST;
            clock_divider_control <= `PDC_CLKDIV_RST;
        end else if (wr_go) begin
            case (req.addr[11:0])
                `PDC_OFF_HALTA: module_halt_reg_a <= hwdata;
                `PDC_OFF_HALTB: module_halt_reg_b <= hwdata;
                `PDC_OFF_HALTC: module_halt_reg_c <= hwdata;
                `PDC_OFF_CLKDIV: clock_divider_control <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // Read data registered in the address phase, ready for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_go) begin
            case (haddr[11:0])
                `PDC_OFF_SBY: hrdata <= {16'h0000, standby_control};
                `PDC_OFF_HALTA: hrdata <= module_halt_reg_a;
                `PDC_OFF_HALTB: hrdata <= module_halt_reg_b;
                `PDC_OFF_HALTC: hrdata <= module_halt_reg_c;
                `PDC_OFF_CLKDIV: hrdata <= {16'h0000, clock_divider_control};
                `PDC_OFF_STATUS: hrdata <= {27'h0000000, state};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    // Settle length from code; reserved codes fall back to the longest
    always_comb begin
        case (sts)
            5'h05: settle_len = 20'h00040;
            5'h06: settle_len = 20'h00200;
            5'h07: settle_len = 20'h00400;
            5'h08: settle_len = 20'h00800;
            5'h09: settle_len = 20'h01000;
            5'h0A: settle_len = 20'h04000;
            5'h0B: settle_len = 20'h08000;
            5'h0C: settle_len = 20'h10000;
            5'h0D: settle_len = 20'h20000;
            5'h0E: settle_len = 20'h40000;
            default: settle_len = 20'h80000;
        endcase
    end

    // Sleep entry and wake decisions
    always_comb begin
        next_state = state;
        case (state)
            pdc_pkg::PDC_RUN: begin
                if (sleep_exec && !sleep_exception_enable) begin
                    if (soft_standby_select && !wdt_watchdog_mode) begin
                        next_state = pdc_pkg::PDC_SWSBY;
                    // Timer halt bits are left out: timers may keep running in clock stop
                    end else if ((module_halt_reg_a | `PDC_TMR_MASK) == 32'hFFFFFFFF) begin
                        next_state = pdc_pkg::PDC_CLKSTOP;
                    end else begin
                        next_state = pdc_pkg::PDC_SLEEP;
                    end
                end
            end
            pdc_pkg::PDC_SLEEP: begin
                if (irq_any) next_state = pdc_pkg::PDC_RUN;
            end
            pdc_pkg::PDC_CLKSTOP: begin
                if (irq_external || irq_timer_wdt) next_state = pdc_pkg::PDC_RUN;
            end
            pdc_pkg::PDC_SWSBY: begin
                if (irq_external) next_state = pdc_pkg::PDC_SETTLE;
            end
            pdc_pkg::PDC_SETTLE: begin
                if (periph_clk_tick && settle_cnt <= 20'h00001) next_state = pdc_pkg::PDC_RUN;
            end
            default: next_state = pdc_pkg::PDC_RUN;
        endcase
    end

    // Mode state; hardware standby pin acts like a hold in run state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= pdc_pkg::PDC_RUN;
        end else if (hw_standby_pin) begin
            state <= pdc_pkg::PDC_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Settle counter on peripheral clock ticks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            settle_cnt <= 20'h00000;
        end else if (state == pdc_pkg::PDC_SWSBY) begin
            settle_cnt <= settle_len;
        end else if (state == pdc_pkg::PDC_SETTLE && periph_clk_tick && settle_cnt != 20'h00000) begin
            settle_cnt <= settle_cnt - 20'h00001;
        end
    end

    // Exception flag follows sleep_exec one cycle later for as long as it is held; resume is a one-cycle pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_exception <= 1'b0;
            wake_resume <= 1'b0;
        end else begin
            sleep_exception <= state == pdc_pkg::PDC_RUN && sleep_exec && sleep_exception_enable;
            wake_resume <= state != pdc_pkg::PDC_RUN && next_state == pdc_pkg::PDC_RUN && !hw_standby_pin;
        end
    end

    // Per-module control outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_halt <= 1'b0;
            osc_stop <= 1'b0;
            wdt_halt <= 1'b0;
            module_halt <= 32'hFFFFFFFF;
            module_reset <= 32'h00000000;
            timer_halt <= 4'hF;
            timer_pin_off <= 1'b0;
            port_hold <= 1'b0;
            port_hiz_n <= 1'b1;
            bus_float_n <= 1'b1;
        end else begin
            cpu_halt <= hw_standby_pin || next_state != pdc_pkg::PDC_RUN;
            osc_stop <= hw_standby_pin || next_state == pdc_pkg::PDC_SWSBY;
            wdt_halt <= hw_standby_pin || next_state == pdc_pkg::PDC_SWSBY;
            if (hw_standby_pin) begin
                module_halt <= 32'hFFFFFFFF;
                module_reset <= 32'hFFFFFFFF;
                timer_halt <= 4'hF;
            end else if (next_state == pdc_pkg::PDC_CLKSTOP || next_state == pdc_pkg::PDC_SWSBY) begin
                module_halt <= 32'hFFFFFFFF;
                module_reset <= 32'h00000001 << `PDC_SCI_BIT;
                timer_halt <= (next_state == pdc_pkg::PDC_SWSBY) ? 4'hF
                    : module_halt_reg_a[`PDC_TMR_HI:`PDC_TMR_LO];
            end else begin
                module_halt <= module_halt_reg_a;
                module_reset <= 32'h00000000;
                timer_halt <= module_halt_reg_a[`PDC_TMR_HI:`PDC_TMR_LO];
            end
            timer_pin_off <= next_state == pdc_pkg::PDC_CLKSTOP;
            port_hold <= next_state == pdc_pkg::PDC_CLKSTOP || next_state == pdc_pkg::PDC_SWSBY;
            port_hiz_n <= !hw_standby_pin;
            bus_float_n <= !(next_state == pdc_pkg::PDC_SWSBY && !bus_output_hold_enable)
                && !hw_standby_pin;
        end
    end
endmodule
`default_nettype wire

// *** hdl/pdc_defs.svh ***
// Constants for the power-down mode controller
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH
`define PDC_OFF_SBY 12'h000
`define PDC_OFF_HALTA 12'h004
`define PDC_OFF_HALTB 12'h008
`define PDC_OFF_HALTC 12'h00C
`define PDC_OFF_CLKDIV 12'h010
`define PDC_OFF_STATUS 12'h014
`define PDC_SBY_RST 16'h4F00
`define PDC_SBY_WMASK 16'hDF80
`define PDC_HALTA_RST 32'hFFFFFFFF
`define PDC_HALTB_RST 32'hFFFFFFFF
`define PDC_HALTC_RST 32'hFFFFFFFF
`define PDC_CLKDIV_RST 16'h0222
`define PDC_BIT_SOFT_STANDBY_SELECT 15
`define PDC_BIT_HOLD 14
`define PDC_BIT_SLEEP_EXCEPTION_ENABLE 7
`define PDC_STS_HI 12
`define PDC_STS_LO 8
`define PDC_TMR_HI 11
`define PDC_TMR_LO 8
`define PDC_TMR_MASK 32'h00000F00
`define PDC_SCI_BIT 0
`endif

// *** hdl/pdc_pkg.sv ***
// Types of the power-down mode controller
package pdc_pkg;
    typedef enum logic [4:0] {
        PDC_RUN = 5'h01,
        PDC_SLEEP = 5'h02,
        PDC_CLKSTOP = 5'h04,
        PDC_SWSBY = 5'h08,
        PDC_SETTLE = 5'h10
    } pdc_state_e;
    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [2:0] size;
        logic [1:0] trans;
        logic sel;
    } pdc_ahb_req_s;
endpackage

// *** sim/pdc_ctrl_props.sv ***
// Concurrent checks on the power-down mode controller ports
`timescale 1ns/1ns
`default_nettype none
module pdc_ctrl_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic sleep_exec,
    input wire logic hw_standby_pin,
    input wire logic sleep_exception,
    input wire logic cpu_halt,
    input wire logic osc_stop,
    input wire logic wdt_halt,
    input wire logic [31:0] module_reset,
    input wire logic timer_pin_off,
    input wire logic wake_resume,
    input wire logic bus_float_n,
    input wire logic port_hiz_n
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Pin held for two edges gives the registered outputs time to land
    chk_hw_standby_halt: assert property (hw_standby_pin ##1 hw_standby_pin |->
        !port_hiz_n && osc_stop && cpu_halt && wdt_halt) else $error("hardware standby outputs wrong");
    chk_hw_standby_reset: assert property (hw_standby_pin ##1 hw_standby_pin |->
        module_reset == 32'hFFFFFFFF) else $error("hardware standby left a module out of reset");
    chk_osc_needs_halt: assert property (osc_stop |-> cpu_halt)
        else $error("oscillator stopped while the core runs");
    chk_pin_off_stop: assert property (timer_pin_off && !hw_standby_pin |-> cpu_halt && !osc_stop)
        else $error("timer pin suppressed outside clock stop");
    chk_serial_reset: assert property ($rose(timer_pin_off) |-> module_reset[0])
        else $error("serial unit not reset in clock stop");
    chk_float_in_sby: assert property (!bus_float_n |-> osc_stop)
        else $error("bus floated outside software standby");
    chk_halt_cause: assert property ($rose(cpu_halt) && !hw_standby_pin && !$past(hw_standby_pin)
        |-> $past(sleep_exec)) else $error("core halted with no sleep instruction");
    chk_exc_no_halt: assert property (sleep_exception |-> !cpu_halt)
        else $error("exception taken but core halted");
    chk_resume_osc: assert property (wake_resume |-> !osc_stop)
        else $error("resume with oscillator stopped");
endmodule
`default_nettype wire

// *** sim/pdc_periph_model.sv ***
// Peripheral clock tick source standing in for the clock divider
`timescale 1ns/1ns
`default_nettype none
module pdc_periph_model #(parameter int DIV = 3) (
    input wire logic hclk,
    input wire logic hresetn,
    output logic periph_clk_tick,
    output logic [31:0] tick_count
);
    logic [7:0] div_cnt;
    // One tick every DIV system cycles; a slow peripheral clock stretches the settle wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= 8'h00;
            periph_clk_tick <= 1'b0;
            tick_count <= 32'h0;
        end else begin
            div_cnt <= (div_cnt == 8'(DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
            periph_clk_tick <= (div_cnt == 8'(DIV - 1));
            tick_count <= tick_count + {31'h0, periph_clk_tick};
        end
    end
endmodule
`default_nettype wire

// *** sim/pdc_ctrl_tb.sv ***
// Self-checking bench for the power-down mode controller
`timescale 1ns/1ns
`default_nettype none
module pdc_ctrl_tb;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, sleep_exec = 1'b0, hw_pin = 1'b0;
    logic wdt_mode = 1'b0, tick, hreadyout, hresp, sexc, chalt, oscs, wdth, pinoff, wres, bfn, phold, phizn;
    logic [2:0] irq = 3'h0;
    logic [1:0] htrans = 2'h0;
    logic [3:0] thalt;
    logic [15:0] ckdiv;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, mhalt, mrst, rd, ticks, r, n0, seen;
    logic [31:0] eq[$];
    string nq[$];
    string seen_n;
    int mismatches = 0, checked = 0, seed = 32'h8782;
    event got;
    always #4 hclk = ~hclk;
    pdc_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sleep_exec(sleep_exec), .hw_standby_pin(hw_pin), .wdt_watchdog_mode(wdt_mode), .irq_any(irq[0]),
        .irq_external(irq[2]), .irq_timer_wdt(irq[1]), .periph_clk_tick(tick), .sleep_exception(sexc),
        .cpu_halt(chalt), .osc_stop(oscs), .wdt_halt(wdth), .module_halt(mhalt), .module_reset(mrst),
        .timer_halt(thalt), .timer_pin_off(pinoff), .wake_resume(wres), .bus_float_n(bfn), .port_hold(phold),
        .port_hiz_n(phizn), .clock_divider_control(ckdiv));
    pdc_periph_model #(.DIV(3)) u_periph (.hclk(hclk), .hresetn(hresetn), .periph_clk_tick(tick), .tick_count(ticks));
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // Monitor takes the oldest note whenever a result is delivered
    always @(got) begin
        check(nq.pop_front(), seen, eq.pop_front());
    end
    task automatic expect_v(input string n, input logic [31:0] s, input logic [31:0] e);
        eq.push_back(e);
        nq.push_back(n);
        seen = s;
        -> got;
        #1;
    endtask
    // Single transfer; read data is taken before this edge's updates land
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        expect_v(n, rd, e);
    endtask
    task automatic wait_for(ref logic s, input logic v);
        for (int i = 0; i < 2000 && s !== v; i++) @(posedge hclk);
    endtask
    task automatic sleep_now;
        @(posedge hclk);
        sleep_exec <= 1'b1;
        @(posedge hclk);
        sleep_exec <= 1'b0;
        @(posedge hclk);
        #1;
    endtask
    // Raise one wake source and hold it until the resume pulse
    task automatic wake(input int k);
        @(posedge hclk);
        irq[k] <= 1'b1;
        n0 = ticks;
        wait_for(wres, 1'b1);
        r = ticks - n0;
        irq[k] <= 1'b0;
        @(posedge hclk);
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk("standby", 32'h0, 32'h4F00);
        rchk("halt_a", 32'h4, 32'hFFFFFFFF);
        rchk("clkdiv", 32'h10, 32'h222);
        rchk("unmapped", 32'h40, 32'h0);
        expect_v("bus_okay", {hreadyout, hresp}, 32'h2);
        expect_v("module_halt", mhalt, 32'hFFFFFFFF);
        bus(1'b1, 32'h0, 32'hFFFF);
        rchk("standby_mask", 32'h0, 32'hDF80);
        r = $random(seed) & 32'hFFFFFFFE;
        bus(1'b1, 32'h4, r);
        bus(1'b1, 32'h10, {16'h0000, r[31:16]});
        bus(1'b1, 32'h0, 32'h4500);
        expect_v("module_halt_w", mhalt, r);
        expect_v("clkdiv_out", {16'h0000, ckdiv}, {16'h0000, r[31:16]});
        sleep_now();
        expect_v("sleep_out", {thalt, phold, oscs, chalt}, {r[11:8], 3'h1});
        rchk("state_sleep", 32'h14, {27'h0, pdc_pkg::PDC_SLEEP});
        wake(0);
        expect_v("sleep_woke", chalt, 32'h0);
        bus(1'b1, 32'h4, 32'hFFFFF0FF);
        sleep_now();
        irq[0] <= 1'b1;
        repeat (6) @(posedge hclk);
        irq[0] <= 1'b0;
        expect_v("clkstop_out", {thalt, phold, oscs, chalt, pinoff, mrst[0]}, 32'h17);
        wake(1);
        wdt_mode <= 1'b1;
        bus(1'b1, 32'h0, 32'hC500);
        sleep_now();
        expect_v("wdt_mode_stop", {oscs, pinoff}, 32'h1);
        wake(1);
        wdt_mode <= 1'b0;
        // Standby with the bus floated, then with it held
        for (int h = 0; h < 2; h++) begin
            bus(1'b1, 32'h0, 32'h8500 | (h << 14));
            sleep_now();
            irq[1:0] <= 2'h3;
            repeat (6) @(posedge hclk);
            irq[1:0] <= 2'h0;
            expect_v("standby_out", {thalt, phold, wdth, oscs, bfn}, {4'hF, 3'h7, h[0]});
            wake(2);
            expect_v("settle_ticks", {31'h0, r >= 64 && r <= 66}, 32'h1);
            rchk("soft_standby_select_kept", 32'h0, 32'h8500 | (h << 14));
        end
        bus(1'b1, 32'h0, 32'h0580);
        @(posedge hclk);
        sleep_exec <= 1'b1;
        wait_for(sexc, 1'b1);
        sleep_exec <= 1'b0;
        expect_v("exception", {sexc, chalt}, 32'h2);
        @(posedge hclk);
        hw_pin <= 1'b1;
        repeat (3) @(posedge hclk);
        #1;
        expect_v("hw_standby", {phizn, oscs, chalt, wdth}, 32'h7);
        expect_v("hw_reset", mrst, 32'hFFFFFFFF);
        tally_and_finish();
    end
endmodule
bind pdc_ctrl pdc_ctrl_props u_props (.hclk(hclk), .hresetn(hresetn), .sleep_exec(sleep_exec),
    .hw_standby_pin(hw_standby_pin), .sleep_exception(sleep_exception), .cpu_halt(cpu_halt), .osc_stop(osc_stop),
    .wdt_halt(wdt_halt), .module_reset(module_reset), .timer_pin_off(timer_pin_off), .wake_resume(wake_resume),
    .bus_float_n(bus_float_n), .port_hiz_n(port_hiz_n));
`default_nettype wire
